// ---- inc/hrp_pkg.sv ----
// constants, register map and carrier types of the high resolution pwm channel
package hrp_pkg;
   localparam int CW = 14;
   localparam int FW = 4;
   localparam int EW = CW + FW;
   localparam int DW = 24;
   // byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_PERIOD = 8'h04;
   localparam logic [7:0] OFS_EV1    = 8'h08;
   localparam logic [7:0] OFS_EV2    = 8'h0C;
   localparam logic [7:0] OFS_EV3    = 8'h10;
   localparam logic [7:0] OFS_EV4    = 8'h14;
   localparam logic [7:0] OFS_SAMP1  = 8'h18;
   localparam logic [7:0] OFS_SAMP2  = 8'h1C;
   localparam logic [7:0] OFS_PHASE  = 8'h20;
   localparam logic [7:0] OFS_ADJA   = 8'h24;
   localparam logic [7:0] OFS_ADJB   = 8'h28;
   localparam logic [7:0] OFS_DEAD   = 8'h2C;
   localparam logic [7:0] OFS_BLANKA = 8'h30;
   localparam logic [7:0] OFS_BLANKB = 8'h34;
   localparam logic [7:0] OFS_IDIV   = 8'h38;
   localparam logic [7:0] OFS_STATUS = 8'h3C;
   localparam logic [7:0] OFS_DUTY   = 8'h40;
   // control field positions, and the end field of the blanking words
   localparam int CTL_EN     = 0;
   localparam int CTL_CLOSED = 1;
   localparam int CTL_POLA   = 2;
   localparam int CTL_POLB   = 3;
   localparam int CTL_OS     = 4;
   localparam int CTL_SYNCEN = 6;
   localparam int CTL_HIRES  = 7;
   localparam int BLK_END    = 16;
   // reset values
   localparam logic [7:0]    RST_CTRL   = 8'h00;
   localparam logic [CW-1:0] RST_PERIOD = 14'h3FFF;
   localparam logic [7:0]    RST_DEAD   = 8'h00;
   localparam logic [7:0]    RST_IDIV   = 8'h00;

   typedef struct packed {
      logic          a;
      logic          b;
      logic [FW-1:0] a_fine;
      logic [FW-1:0] b_fine;
   } hrp_drive_t;

   typedef struct packed {
      logic sample;
      logic sample2;
      logic sync_out;
      logic blank_a;
      logic blank_b;
      logic period_evt;
      logic adc_trig;
   } hrp_event_t;
endpackage

// ---- rtl/hrp_channel.sv ----
// high resolution pwm channel with apb register file
`timescale 1ns/1ps
module hrp_channel
(
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic [31:0]               prdata,
   // compensator duty input
   input  wire logic [hrp_pkg::DW-1:0] duty_in,
   input  wire logic                 duty_valid,
   // synchronisation input
   input  wire logic                 sync_in,
   // switch drive and events
   output hrp_pkg::hrp_drive_t       drive,
   output hrp_pkg::hrp_event_t       events
);
   import hrp_pkg::*;

   typedef struct packed {
      logic [7:0]    ctrl;
      logic [CW-1:0] per_shadow;
      logic [CW-1:0] per_act;
      logic [CW-1:0] ev1;
      logic [EW-1:0] ev2;
      logic [EW-1:0] ev3;
      logic [EW-1:0] ev4;
      logic [11:0]   samp1;
      logic [11:0]   samp2;
      logic [CW-1:0] phase;
      logic [15:0]   adj_a;
      logic [15:0]   adj_b;
      logic [7:0]    dead;
      logic [CW-1:0] blka_beg;
      logic [CW-1:0] blka_end;
      logic [CW-1:0] blkb_beg;
      logic [CW-1:0] blkb_end;
      logic [7:0]    idiv;
      logic [7:0]    idiv_cnt;
      logic [DW-1:0] duty;
      logic [CW-1:0] cnt;
      logic          raw_a;
      logic          raw_b;
      logic          on_a;
      logic          on_b;
      logic [7:0]    off_a;
      logic [7:0]    off_b;
      logic [2:0]    os_left;
      logic [CW-1:0] os_cnt;
      logic [31:0]   rdata;
      hrp_drive_t    drv;
      hrp_event_t    evt;
   } state_t;

   state_t s_reg;
   state_t s_next;

   // signed adjust in fine steps (16 per clock) on an 18-bit edge, clamped to the counter range
   function automatic logic [EW-1:0] adj_edge(input logic [EW-1:0] base, input logic [15:0] adj);
      logic signed [EW+1:0] sum;
      sum = $signed({2'b00, base}) + $signed({{(EW-14){adj[15]}}, adj});
      if (sum < 0)
      begin
         adj_edge = '0;
      end
      else if (sum[EW])
      begin
         adj_edge = '1;
      end
      else
      begin
         adj_edge = sum[EW-1:0];
      end
   endfunction

   // closed loop trailing edge: event 1 plus duty times period
   function automatic logic [EW-1:0] duty_edge(input logic [CW-1:0] rise, input logic [DW-1:0] d,
                                               input logic [CW-1:0] per);
      logic [DW-1+CW-1:0] prod;
      logic [EW:0]        sum;
      prod = d[DW-2:0] * per;
      if (d[DW-1])
      begin
         prod = '0;
      end
      sum = {1'b0, rise, {FW{1'b0}}} + {1'b0, prod[DW-2+CW:DW-1-FW]};
      duty_edge = sum[EW] ? '1 : sum[EW-1:0];
   endfunction

   // an output may switch on only once the other has rested for the dead time
   function automatic logic may_turn_on(input logic raw, input logic other_busy, input logic [7:0] other_off,
                                        input logic [7:0] dead);
      may_turn_on = raw && !other_busy && other_off >= dead;
   endfunction

   // off-time counters saturate so a long idle never wraps back under the dead time
   function automatic logic [7:0] off_count(input logic on, input logic [7:0] cnt);
      if (on)
      begin
         off_count = 8'h00;
      end
      else if (cnt == 8'hFF)
      begin
         off_count = 8'hFF;
      end
      else
      begin
         off_count = cnt + 8'h01;
      end
   endfunction

   logic          acc;
   logic          wr;
   logic          rd;
   logic          mapped;
   logic          en;
   logic          hires;
   logic          wrap;
   logic          q_en;
   logic [EW-1:0] fall_a;
   logic [EW-1:0] rise_b;
   logic [EW-1:0] fall_b;
   logic [EW-1:0] base_a;
   logic [CW-1:0] sub_len;
   logic          a_on;
   logic          b_on;

   always_comb
   begin
      acc    = psel & penable;
      wr     = acc & pwrite;
      rd     = psel & ~penable & ~pwrite;
      mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_DUTY);
      en     = s_reg.ctrl[CTL_EN];
      hires  = s_reg.ctrl[CTL_HIRES];
      pready  = penable;
      pslverr = acc & ~mapped;
      prdata  = s_reg.rdata;

      s_next = s_reg;
      s_next.evt = '0;

      // register writes take effect at the access edge
      if (wr && mapped)
      begin
         unique case (paddr)
            OFS_CTRL:   s_next.ctrl       = pwdata[7:0];
            OFS_PERIOD: s_next.per_shadow = pwdata[CW-1:0];
            OFS_EV1:    s_next.ev1        = pwdata[CW-1:0];
            OFS_EV2:    s_next.ev2        = pwdata[EW-1:0];
            OFS_EV3:    s_next.ev3        = pwdata[EW-1:0];
            OFS_EV4:    s_next.ev4        = pwdata[EW-1:0];
            OFS_SAMP1:  s_next.samp1      = pwdata[11:0];
            OFS_SAMP2:  s_next.samp2      = pwdata[11:0];
            OFS_PHASE:  s_next.phase      = pwdata[CW-1:0];
            OFS_ADJA:   s_next.adj_a      = pwdata[15:0];
            OFS_ADJB:   s_next.adj_b      = pwdata[15:0];
            OFS_DEAD:   s_next.dead       = pwdata[7:0];
            OFS_BLANKA:
            begin
               s_next.blka_beg = pwdata[CW-1:0];
               s_next.blka_end = pwdata[BLK_END+CW-1:BLK_END];
            end
            OFS_BLANKB:
            begin
               s_next.blkb_beg = pwdata[CW-1:0];
               s_next.blkb_end = pwdata[BLK_END+CW-1:BLK_END];
            end
            OFS_IDIV:   s_next.idiv       = pwdata[7:0];
            OFS_DUTY:   s_next.duty       = pwdata[DW-1:0];
            default:    s_next.ctrl       = s_reg.ctrl;
         endcase
      end

      // compensator update; software write to the same word loses to it
      if (duty_valid)
      begin
         s_next.duty = duty_in;
      end

      // read data captured in the setup cycle, shown during access
      if (rd)
      begin
         unique case (paddr)
            OFS_CTRL:   s_next.rdata = {24'h000000, s_reg.ctrl};
            OFS_PERIOD: s_next.rdata = {18'h00000, s_reg.per_shadow};
            OFS_EV1:    s_next.rdata = {18'h00000, s_reg.ev1};
            OFS_EV2:    s_next.rdata = {14'h0000, s_reg.ev2};
            OFS_EV3:    s_next.rdata = {14'h0000, s_reg.ev3};
            OFS_EV4:    s_next.rdata = {14'h0000, s_reg.ev4};
            OFS_SAMP1:  s_next.rdata = {20'h00000, s_reg.samp1};
            OFS_SAMP2:  s_next.rdata = {20'h00000, s_reg.samp2};
            OFS_PHASE:  s_next.rdata = {18'h00000, s_reg.phase};
            OFS_ADJA:   s_next.rdata = {16'h0000, s_reg.adj_a};
            OFS_ADJB:   s_next.rdata = {16'h0000, s_reg.adj_b};
            OFS_DEAD:   s_next.rdata = {24'h000000, s_reg.dead};
            OFS_BLANKA: s_next.rdata = {2'h0, s_reg.blka_end, 2'h0, s_reg.blka_beg};
            OFS_BLANKB: s_next.rdata = {2'h0, s_reg.blkb_end, 2'h0, s_reg.blkb_beg};
            OFS_IDIV:   s_next.rdata = {24'h000000, s_reg.idiv};
            OFS_STATUS: s_next.rdata = {14'h0000, s_reg.drv.b, s_reg.drv.a, 2'h0, s_reg.cnt};
            OFS_DUTY:   s_next.rdata = {8'h00, s_reg.duty};
            default:    s_next.rdata = 32'h00000000;
         endcase
      end

      // edge positions; closed loop replaces only event 2
      base_a = s_reg.ctrl[CTL_CLOSED] ? duty_edge(s_reg.ev1, s_reg.duty, s_reg.per_act) : s_reg.ev2;
      fall_a = adj_edge(base_a, s_reg.adj_a);
      rise_b = s_reg.ev3;
      fall_b = adj_edge(s_reg.ev4, s_reg.adj_b);
      if (!hires)
      begin
         fall_a[FW-1:0] = '0;
         rise_b[FW-1:0] = '0;
         fall_b[FW-1:0] = '0;
      end

      wrap    = s_reg.cnt >= s_reg.per_act;
      q_en    = s_reg.cnt[1:0] == 2'b00;
      // spacing uses the full cycle length, one more than the period count
      sub_len = CW'(({1'b0, s_reg.per_act} + 15'h0001) >> s_reg.ctrl[CTL_OS+1:CTL_OS]);

      if (!en)
      begin
         s_next.cnt     = '0;
         s_next.per_act = s_reg.per_shadow;
         s_next.raw_a   = 1'b0;
         s_next.raw_b   = 1'b0;
         s_next.os_left = '0;
      end
      else
      begin
         // time base
         if (s_reg.ctrl[CTL_SYNCEN] && sync_in)
         begin
            s_next.cnt = '0;
         end
         else if (wrap)
         begin
            s_next.cnt     = '0;
            s_next.per_act = s_reg.per_shadow;
            if (s_reg.idiv_cnt >= s_reg.idiv)
            begin
               s_next.idiv_cnt       = '0;
               s_next.evt.period_evt = 1'b1;
               s_next.evt.adc_trig   = 1'b1;
            end
            else
            begin
               s_next.idiv_cnt = s_reg.idiv_cnt + 8'h01;
            end
         end
         else
         begin
            s_next.cnt = s_reg.cnt + 14'h0001;
         end

         // raw edges, fall wins when both land on one count
         if (s_reg.cnt == s_reg.ev1)
         begin
            s_next.raw_a = 1'b1;
         end
         if (s_reg.cnt == fall_a[EW-1:FW])
         begin
            s_next.raw_a = 1'b0;
         end
         if (s_reg.cnt == rise_b[EW-1:FW])
         begin
            s_next.raw_b = 1'b1;
         end
         if (s_reg.cnt == fall_b[EW-1:FW])
         begin
            s_next.raw_b = 1'b0;
         end

         // phase sync toward followers
         if (s_reg.cnt == s_reg.phase)
         begin
            s_next.evt.sync_out = 1'b1;
         end

         // sample triggers compared at the quarter rate
         if (q_en && s_reg.cnt[CW-1:2] == s_reg.samp1)
         begin
            s_next.evt.sample = 1'b1;
            s_next.os_left    = 3'((1 << s_reg.ctrl[CTL_OS+1:CTL_OS]) - 1);
            s_next.os_cnt     = '0;
         end
         else if (s_reg.os_left != 3'd0)
         begin
            // extra samples spaced by period over the oversample factor
            if (s_reg.os_cnt + 14'h0001 >= sub_len)
            begin
               s_next.evt.sample = 1'b1;
               s_next.os_cnt     = '0;
               s_next.os_left    = s_reg.os_left - 3'd1;
            end
            else
            begin
               s_next.os_cnt = s_reg.os_cnt + 14'h0001;
            end
         end
         if (q_en && s_reg.cnt[CW-1:2] == s_reg.samp2)
         begin
            s_next.evt.sample2 = 1'b1;
         end
      end

      // blanking windows, begin inclusive and end exclusive
      s_next.evt.blank_a = en && s_next.cnt >= s_reg.blka_beg && s_next.cnt < s_reg.blka_end;
      s_next.evt.blank_b = en && s_next.cnt >= s_reg.blkb_beg && s_next.cnt < s_reg.blkb_end;

      // dead time works on the internal on-state, so an inverted pin cannot block the other side
      a_on         = may_turn_on(s_next.raw_a, s_reg.on_b && s_next.raw_b, s_reg.off_b, s_reg.dead);
      b_on         = may_turn_on(s_next.raw_b, a_on, s_reg.off_a, s_reg.dead);
      s_next.on_a  = a_on;
      s_next.on_b  = b_on;
      s_next.off_a = off_count(a_on, s_reg.off_a);
      s_next.off_b = off_count(b_on, s_reg.off_b);

      // polarity and fine code for the external delay line
      s_next.drv.a      = a_on ^ s_reg.ctrl[CTL_POLA];
      s_next.drv.b      = b_on ^ s_reg.ctrl[CTL_POLB];
      s_next.drv.a_fine = fall_a[FW-1:0];
      s_next.drv.b_fine = b_on ? fall_b[FW-1:0] : rise_b[FW-1:0];
      if (!en)
      begin
         s_next.drv.a_fine = '0;
         s_next.drv.b_fine = '0;
      end
   end

   // the internal on-state is kept apart from the polarity-applied pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg            <= '0;
         s_reg.ctrl       <= RST_CTRL;
         s_reg.per_shadow <= RST_PERIOD;
         s_reg.per_act    <= RST_PERIOD;
         s_reg.dead       <= RST_DEAD;
         s_reg.idiv       <= RST_IDIV;
         s_reg.off_a      <= 8'hFF;
         s_reg.off_b      <= 8'hFF;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign drive  = s_reg.drv;
   assign events = s_reg.evt;
endmodule

// ---- sim/hrp_chk.sv ----
// port assertions of the pwm channel
`timescale 1ns/1ps
module hrp_chk
(
   // clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // apb
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [7:0]             paddr,
   input wire logic [31:0]            pwdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic [31:0]            prdata,
   // duty, sync and outputs
   input wire logic [hrp_pkg::DW-1:0] duty_in,
   input wire logic                   duty_valid,
   input wire logic                   sync_in,
   input wire hrp_pkg::hrp_drive_t    drive,
   input wire hrp_pkg::hrp_event_t    events
);
   import hrp_pkg::*;
   logic [7:0]    ctl_q;
   logic [CW-1:0] per_q;
   logic [CW-1:0] ev1_q;
   logic [CW-1:0] ph_q;
   wire           map_ok = paddr[1:0] == 2'h0 && paddr <= OFS_DUTY;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadows of only the settings that the properties need
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ctl_q <= RST_CTRL;
         per_q <= RST_PERIOD;
         ev1_q <= '0;
         ph_q  <= '0;
      end
      else if (psel && penable && pwrite && map_ok)
         case (paddr)
            OFS_CTRL:   ctl_q <= pwdata[7:0];
            OFS_PERIOD: per_q <= pwdata[CW-1:0];
            OFS_EV1:    ev1_q <= pwdata[CW-1:0];
            OFS_PHASE:  ph_q <= pwdata[CW-1:0];
            default:    ;
         endcase
   a_zero_wait: assert property (pready == penable)
      else $error("pready differs from penable");
   a_err_map: assert property (psel && penable |-> pslverr == !map_ok)
      else $error("pslverr wrong for address");
   a_per_read: assert property (psel && penable && !pwrite && paddr == OFS_PERIOD |-> prdata == {18'h0, per_q})
      else $error("period readback wrong");
   a_ev1_read: assert property (psel && penable && !pwrite && paddr == OFS_EV1 |-> prdata == {18'h0, ev1_q})
      else $error("event 1 readback wrong");
   // polarity is taken one clock back because the outputs are registered
   a_dead_excl: assert property (!((drive.a ^ $past(ctl_q[CTL_POLA])) && (drive.b ^ $past(ctl_q[CTL_POLB]))))
      else $error("outputs a and b both active");
   a_adc_pair: assert property (events.adc_trig |-> events.period_evt)
      else $error("converter trigger off a period event");
   a_per_pulse: assert property (events.period_evt |=> !events.period_evt)
      else $error("period event longer than one clock");
   a_fine_zero: assert property (!$past(ctl_q[CTL_HIRES]) |-> drive.a_fine == 4'h0 && drive.b_fine == 4'h0)
      else $error("fine bits set with high resolution off");
   a_sync_hold: assert property ($past(ctl_q[CTL_SYNCEN], 2) && $past(ctl_q[CTL_EN], 2) && $past(ph_q) != 0
      && $past(sync_in) && $past(sync_in, 2) |-> !events.sync_out)
      else $error("sync output while counter held at zero");
   a_sync_pulse: assert property (events.sync_out |=> !events.sync_out)
      else $error("sync output longer than one clock");
endmodule
bind hrp_channel hrp_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .duty_in(duty_in),
   .duty_valid(duty_valid), .sync_in(sync_in), .drive(drive), .events(events));

// ---- sim/hrp_comp_model.sv ----
// compensator model: answers the most recent sample request with a duty value after a set latency
`timescale 1ns/1ps
module hrp_comp_model
(
   // clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // request and settings
   input wire logic                   sample,
   input wire logic [3:0]             lat,
   input wire logic [hrp_pkg::DW-1:0] duty_set,
   // duty toward the channel
   output logic [hrp_pkg::DW-1:0]     duty_in,
   output logic                       duty_valid
);
   logic [4:0] wait_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         wait_q     <= 5'h0;
         duty_valid <= 1'b0;
         duty_in    <= '0;
      end
      else
      begin
         duty_valid <= 1'b0;
         // between answers the bus toggles so a stale value is never mistaken for data
         duty_in    <= ~duty_in;
         if (sample)
            wait_q <= {1'b0, lat} + 5'h1;
         else if (wait_q == 5'h1)
         begin
            duty_valid <= 1'b1;
            duty_in    <= {1'b0, duty_set[22:0]};
            wait_q     <= 5'h0;
         end
         else if (wait_q != 5'h0)
            wait_q <= wait_q - 5'h1;
      end
endmodule

// ---- sim/hrp_channel_tb.sv ----
// self-checking bench of the pwm channel
`timescale 1ns/1ps
module hrp_channel_tb;
   import hrp_pkg::*;
   logic          pclk, presetn, psel, penable, pwrite, sync_in, pready, pslverr, duty_valid, err_q, hold;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata, rd_q, seed;
   logic [DW-1:0] duty_in, duty_set;
   logic [3:0]    lat;
   hrp_drive_t    drive;
   hrp_event_t    events;
   int            n_fail, checks_done, n_a, n_b, n_smp, n_per, n_adc, n_syn;
   logic [7:0]    ra [5] = '{OFS_CTRL, OFS_PERIOD, OFS_DEAD, OFS_IDIV, OFS_EV1};
   logic [31:0]   rv [5] = '{RST_CTRL, RST_PERIOD, RST_DEAD, RST_IDIV, 0};
   logic [7:0]    wa [9] = '{OFS_PERIOD, OFS_EV1, OFS_EV2, OFS_EV3, OFS_EV4, OFS_SAMP1, OFS_PHASE, OFS_DEAD, OFS_IDIV};
   logic [31:0]   wm [9] = '{32'h3FFF, 32'h3FFF, 32'h3FFFF, 32'h3FFFF, 32'h3FFFF, 32'hFFF, 32'h3FFF, 32'hFF, 32'hFF};
   logic [7:0]    ca [12] = '{OFS_PERIOD, OFS_EV1, OFS_EV2, OFS_EV3, OFS_EV4, OFS_ADJA, OFS_ADJB, OFS_SAMP1,
                              OFS_PHASE, OFS_DEAD, OFS_IDIV, OFS_CTRL};
   logic [31:0]   cd [12] = '{9, 2, 32'h60, 32'h70, 32'h90, 0, 0, 0, 5, 0, 0, 1};

   hrp_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .duty_in(duty_in),
      .duty_valid(duty_valid), .sync_in(sync_in), .drive(drive), .events(events));
   hrp_comp_model u_comp (.pclk(pclk), .presetn(presetn), .sample(events.sample), .lat(lat), .duty_set(duty_set),
      .duty_in(duty_in), .duty_valid(duty_valid));

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   function logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // clocks an output is active per run: edges land one clock after the compare
   function int span(input int rise, input int fall, input int periods);
      return (fall - rise) * periods;
   endfunction
   // closed loop: A falls at event 1 plus duty times period, coarse part only
   function int closed_fall(input int rise, input logic [23:0] d, input int per);
      return rise + int'((64'(d) * per) >> 23);
   endfunction

   task give_verdict;
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 16)
      begin
         @(posedge pclk);
         i++;
      end
      if (i == 16)
      begin
         n_fail++;
         give_verdict;
      end
      rd_q = prdata;
      err_q = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task run(input int n);
      n_a = 0;
      n_b = 0;
      n_smp = 0;
      n_per = 0;
      n_adc = 0;
      n_syn = 0;
      repeat (n)
      begin
         // counted mid-cycle, away from the edge that launches the outputs
         @(negedge pclk);
         n_a += drive.a;
         n_b += drive.b;
         n_smp += events.sample;
         n_per += events.period_evt;
         n_adc += events.adc_trig;
         n_syn += events.sync_out;
         @(posedge pclk);
         seed = xs(seed);
         if (!hold)
         begin
            duty_set <= seed[23:0];
         end
         lat <= seed[27:24];
      end
   endtask

   initial
   begin
      {presetn, psel, penable, pwrite, sync_in, paddr, pwdata, duty_set, lat, hold} = '0;
      seed = 32'hF96652BB;
      n_fail = 0;
      checks_done = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[i])
      begin
         apb(1'b0, ra[i], 32'h0);
         chk("reset_value", rv[i], rd_q);
      end
      apb(1'b1, 8'h44, seed);
      chk("unmapped_wr_err", 1, err_q);
      apb(1'b0, 8'h06, 32'h0);
      chk("unaligned_rd_err", 1, err_q);
      chk("unaligned_rd_data", 0, rd_q);
      repeat (3)
         foreach (wa[i])
         begin
            seed = xs(seed);
            apb(1'b1, wa[i], seed);
            apb(1'b0, wa[i], 32'h0);
            chk("readback", seed & wm[i], rd_q);
         end
      foreach (ca[i]) apb(1'b1, ca[i], cd[i]);
      run(20);
      run(100);
      chk("a_on", span(2, 6, 10), n_a);
      chk("b_on", span(7, 9, 10), n_b);
      chk("wraps", 10, n_per);
      chk("adc_trig", 10, n_adc);
      chk("sync_out", 10, n_syn);
      apb(1'b1, OFS_ADJA, 32'h10);
      apb(1'b1, OFS_ADJB, 32'hFFF0);
      run(20);
      run(100);
      chk("a_adjusted", span(2, 7, 10), n_a);
      chk("b_adjusted", span(7, 8, 10), n_b);
      apb(1'b1, OFS_ADJA, 32'h0);
      apb(1'b1, OFS_ADJB, 32'h0);
      apb(1'b1, OFS_PERIOD, 32'd19);
      run(40);
      run(100);
      chk("new_period", 5, n_per);
      chk("a_new_period", span(2, 6, 5), n_a);
      apb(1'b1, OFS_CTRL, 32'h5);
      run(40);
      run(100);
      chk("a_inverted", 100 - span(2, 6, 5), n_a);
      hold = 1'b1;
      duty_set <= 24'h400000;
      apb(1'b1, OFS_CTRL, 32'h83);
      run(40);
      run(100);
      chk("a_closed", span(2, closed_fall(2, 24'h400000, 19), 5), n_a);
      @(negedge pclk);
      chk("a_fine", int'((64'(24'h400000) * 19) >> 19) & 15, drive.a_fine);
      hold = 1'b0;
      apb(1'b1, OFS_PERIOD, 32'd63);
      apb(1'b1, OFS_SAMP1, 32'h1);
      for (int os = 0; os < 4; os++)
      begin
         apb(1'b1, OFS_CTRL, 32'h1 | (os << 4));
         run(64);
         run(256);
         chk("samples", 4 << os, n_smp);
      end
      apb(1'b1, OFS_IDIV, 32'h3);
      run(64);
      run(512);
      chk("divided_trig", 2, n_adc);
      apb(1'b1, OFS_PERIOD, 32'd9);
      apb(1'b1, OFS_IDIV, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h41);
      run(70);
      sync_in <= 1'b1;
      run(3);
      run(50);
      chk("sync_held", 0, n_syn);
      chk("wraps_held", 0, n_per);
      sync_in <= 1'b0;
      run(20);
      run(100);
      chk("sync_free", 10, n_syn);
      apb(1'b1, OFS_EV3, 32'h50);
      apb(1'b1, OFS_DEAD, 32'h2);
      apb(1'b1, OFS_CTRL, 32'h49);
      run(20);
      run(100);
      // b rises at 5 but waits until a has rested two clocks after its fall at 6
      chk("dead_a", span(2, 6, 10), n_a);
      chk("dead_b_inverted", 100 - span(6 + 2, 9, 10), n_b);
      give_verdict;
   end
endmodule
